// ### core/spi_ctl_pkg.sv
package spi_ctl_pkg;

  // -----------------------------------------------------------------
  // widths
  // -----------------------------------------------------------------
  localparam int FRAME_W = 16;
  localparam int DIV_W = 4;
  localparam int HALF_W = 5;
  localparam int EDGE_W = 5;
  localparam int FIFO_W = 16;
  localparam int FIFO_DEPTH = 4;

  // -----------------------------------------------------------------
  // frame lengths as last clock edge index (two edges per bit)
  // -----------------------------------------------------------------
  localparam logic [EDGE_W-1:0] LAST_EDGE_8 = 5'h0F;
  localparam logic [EDGE_W-1:0] LAST_EDGE_16 = 5'h1F;
  localparam logic [EDGE_W-1:0] FIRST_EDGE = 5'h00;

  // -----------------------------------------------------------------
  // bit positions of the two frame sizes
  // -----------------------------------------------------------------
  localparam int MSB_8 = 7;
  localparam int MSB_16 = 15;

  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [FRAME_W-1:0] DATA_RST = 16'h0000;
  localparam logic [HALF_W-1:0] DIV_RST = 5'h00;
  localparam logic CS_DRIVE_LVL = 1'h0;  // level driven on chip select
  localparam logic TX_EMPTY_RST = 1'h1;

  // -----------------------------------------------------------------
  // shifter states, gray along idle -> shift -> hold
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SHIFT = 2'h1,
    ST_HOLD = 2'h3
  } shift_state_t;

endpackage : spi_ctl_pkg

// ### core/spi_mode_cs_sck_control.sv
// Contract
// - both select bits clear: full duplex
// - receive-only: master uses miso, slave mosi
// - single-line: master on mosi, slave on miso
// - single-line direction one transmits, zero receives
// - master hardware select output drives low
// - master select input low with select output off: fault, fall to slave
// - fault blocks enable/master; status then write clears
// - master soft select level zero: fault
// - hardware-selected slave works only while pin low
// - soft-selected slave uses level bit, zero selects
// - master drives serial clock, slave receives it
// - clock divided by field plus extended bit
// - master receive-only clocks while enabled
// - 8/16 bit frames, order, polarity, phase
// - busy, empty, full and error flags
`timescale 1ns/1ps
`default_nettype none

module spi_mode_cs_sck_control (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // control register one writes and status accesses
  input wire logic ctrl_write_i,
  input wire logic ctrl_enable_i,
  input wire logic ctrl_master_i,
  input wire logic status_access_i,
  // configuration levels
  input wire logic single_line_enable_i,
  input wire logic receive_only_select_i,
  input wire logic single_line_direction_i,
  input wire logic hw_select_output_enable_i,
  input wire logic soft_select_enable_i,
  input wire logic soft_select_level_i,
  input wire logic error_interrupt_enable_i,
  input wire logic clock_idle_polarity_i,
  input wire logic clock_sample_phase_i,
  input wire logic [spi_ctl_pkg::DIV_W-1:0] master_clock_divider_i,
  input wire logic extended_divider_enable_i,
  input wire logic frame_16bit_i,
  input wire logic lsb_first_i,
  // transmit data stream
  input wire logic tx_valid_i,
  input wire logic [spi_ctl_pkg::FRAME_W-1:0] tx_data_i,
  output logic tx_ready_o,
  // receive data and flag clears
  input wire logic rx_read_i,
  input wire logic overflow_clear_i,
  output logic [spi_ctl_pkg::FRAME_W-1:0] rx_data_o,
  // status
  output logic interface_enable_o,
  output logic master_select_o,
  output logic mode_fault_flag_o,
  output logic rx_buffer_full_flag_o,
  output logic rx_overflow_flag_o,
  output logic tx_buffer_empty_flag_o,
  output logic busy_flag_o,
  output logic error_irq_o,
  // serial pins
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe_o,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire logic cs_i,
  output logic cs_o,
  output logic cs_oe_o
);

  typedef struct packed {
    spi_ctl_pkg::shift_state_t state;
    logic enable;
    logic master;
    logic fault;
    logic fault_armed;
    logic [spi_ctl_pkg::HALF_W-1:0] div_cnt;
    logic [spi_ctl_pkg::EDGE_W-1:0] edge_cnt;
    logic [spi_ctl_pkg::FRAME_W-1:0] tx_sr;
    logic [spi_ctl_pkg::FRAME_W-1:0] rx_sr;
    logic [spi_ctl_pkg::FRAME_W-1:0] rx_data;
    logic sck_s1, sck_s2, sck_s3;
    logic cs_s1, cs_s2;
    logic mosi_s1, mosi_s2;
    logic miso_s1, miso_s2;
    logic sck, sck_oe, mosi, mosi_oe, miso, miso_oe, cs, cs_oe;
    logic rx_full, overflow, tx_empty, busy, err_irq;
  } ctl_state_t;

  ctl_state_t st_ff;
  ctl_state_t nxt_st;

  logic fifo_take;
  logic fifo_valid;
  logic [spi_ctl_pkg::FRAME_W-1:0] fifo_data;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // bit presented on the data line
  function automatic logic out_bit(input logic [15:0] sr, input logic f16, input logic lsb);
    if (lsb) begin
      out_bit = sr[0];
    end else begin
      out_bit = f16 ? sr[spi_ctl_pkg::MSB_16] : sr[spi_ctl_pkg::MSB_8];
    end
  endfunction : out_bit

  // advance the transmit shifter by one bit
  function automatic logic [15:0] shift_out(input logic [15:0] sr, input logic lsb);
    shift_out = lsb ? {1'b0, sr[15:1]} : {sr[14:0], 1'b0};
  endfunction : shift_out

  // collect one received bit in frame order
  function automatic logic [15:0] shift_in(input logic [15:0] sr, input logic b,
                                           input logic f16, input logic lsb);
    if (!lsb) begin
      shift_in = {sr[14:0], b};
    end else if (f16) begin
      shift_in = {b, sr[15:1]};
    end else begin
      shift_in = {8'h00, b, sr[7:1]};
    end
  endfunction : shift_in

  // -----------------------------------------------------------------
  // transmit buffer
  // -----------------------------------------------------------------
  spi_tx_fifo #(
    .WIDTH(spi_ctl_pkg::FIFO_W),
    .DEPTH(spi_ctl_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_data_i(tx_data_i),
    .in_ready_o(tx_ready_o),
    .out_ready_i(fifo_take),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data)
  );

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    logic bidir, tx_cap, rx_cap, rx_only;
    logic selected, slave_act, fault_hit, tick, step, sample, rx_bit;
    logic [spi_ctl_pkg::EDGE_W-1:0] last_edge;
    logic [spi_ctl_pkg::HALF_W-1:0] half;
    logic [spi_ctl_pkg::FRAME_W-1:0] rx_new;
    bidir = single_line_enable_i;
    tx_cap = bidir ? single_line_direction_i : !receive_only_select_i;
    rx_cap = !bidir || !single_line_direction_i;
    rx_only = !tx_cap;
    selected = soft_select_enable_i ? !soft_select_level_i : !st_ff.cs_s2;
    slave_act = st_ff.enable && !st_ff.master && selected;
    fault_hit = st_ff.master && (soft_select_enable_i ? !soft_select_level_i
                : (!hw_select_output_enable_i && !st_ff.cs_s2));
    half = {extended_divider_enable_i, master_clock_divider_i};
    tick = (st_ff.div_cnt == half);
    last_edge = frame_16bit_i ? spi_ctl_pkg::LAST_EDGE_16 : spi_ctl_pkg::LAST_EDGE_8;
    step = st_ff.master ? tick : (st_ff.sck_s2 ^ st_ff.sck_s3);
    sample = (st_ff.edge_cnt[0] == clock_sample_phase_i);
    rx_bit = (st_ff.master ^ bidir) ? st_ff.miso_s2 : st_ff.mosi_s2;
    rx_new = st_ff.rx_sr;
    fifo_take = 1'b0;
    nxt_st = st_ff;

    // pin synchronisers
    nxt_st.sck_s1 = sck_i;
    nxt_st.sck_s2 = st_ff.sck_s1;
    nxt_st.sck_s3 = st_ff.sck_s2;
    nxt_st.cs_s1 = cs_i;
    nxt_st.cs_s2 = st_ff.cs_s1;
    nxt_st.mosi_s1 = mosi_i;
    nxt_st.mosi_s2 = st_ff.mosi_s1;
    nxt_st.miso_s1 = miso_i;
    nxt_st.miso_s2 = st_ff.miso_s1;

    // clock divider, free running whenever the shifter is not idle
    nxt_st.div_cnt = (tick || st_ff.state == spi_ctl_pkg::ST_IDLE) ?
                     spi_ctl_pkg::DIV_RST : st_ff.div_cnt + 1'b1;

    // flag clears
    if (rx_read_i) begin
      nxt_st.rx_full = 1'b0;
    end
    if (overflow_clear_i) begin
      nxt_st.overflow = 1'b0;
    end

    // shifter sequencing
    unique case (st_ff.state)
      spi_ctl_pkg::ST_IDLE: begin
        if (st_ff.master && st_ff.enable && (rx_only || fifo_valid)) begin
          nxt_st.state = spi_ctl_pkg::ST_SHIFT;
        end else if (slave_act) begin
          nxt_st.state = spi_ctl_pkg::ST_SHIFT;
        end
        if (nxt_st.state == spi_ctl_pkg::ST_SHIFT) begin
          fifo_take = tx_cap && fifo_valid;
          nxt_st.tx_sr = fifo_take ? fifo_data : spi_ctl_pkg::DATA_RST;
          nxt_st.rx_sr = spi_ctl_pkg::DATA_RST;
          nxt_st.edge_cnt = spi_ctl_pkg::FIRST_EDGE;
        end
      end
      spi_ctl_pkg::ST_SHIFT: begin
        if (!st_ff.master && !slave_act) begin
          nxt_st.state = spi_ctl_pkg::ST_IDLE;
        end else if (step) begin
          if (sample) begin
            rx_new = shift_in(st_ff.rx_sr, rx_bit, frame_16bit_i, lsb_first_i);
            nxt_st.rx_sr = rx_new;
          end else if (st_ff.edge_cnt != spi_ctl_pkg::FIRST_EDGE) begin
            nxt_st.tx_sr = shift_out(st_ff.tx_sr, lsb_first_i);
          end
          if (st_ff.master) begin
            nxt_st.sck = !st_ff.sck;
          end
          if (st_ff.edge_cnt == last_edge) begin
            nxt_st.state = st_ff.master ? spi_ctl_pkg::ST_HOLD : spi_ctl_pkg::ST_IDLE;
            if (rx_cap) begin
              nxt_st.rx_data = rx_new;
              nxt_st.overflow = nxt_st.overflow || st_ff.rx_full;
              nxt_st.rx_full = 1'b1;
            end
          end else begin
            nxt_st.edge_cnt = st_ff.edge_cnt + 1'b1;
          end
        end
      end
      spi_ctl_pkg::ST_HOLD: begin
        if (tick) begin
          nxt_st.state = spi_ctl_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_st.state = spi_ctl_pkg::ST_IDLE;
      end
    endcase

    // idle serial clock level
    if (st_ff.state != spi_ctl_pkg::ST_SHIFT) begin
      nxt_st.sck = clock_idle_polarity_i;
    end

    // control register one write and fault clear sequence
    if (ctrl_write_i) begin
      nxt_st.enable = ctrl_enable_i && !st_ff.fault;
      nxt_st.master = ctrl_master_i && !st_ff.fault;
      if (st_ff.fault_armed) begin
        nxt_st.fault = 1'b0;
        nxt_st.fault_armed = 1'b0;
      end
    end
    if (status_access_i && st_ff.fault) begin
      nxt_st.fault_armed = 1'b1;
    end

    // mode fault: drop to slave, disabled; set beats clear
    if (fault_hit) begin
      nxt_st.fault = 1'b1;
      nxt_st.fault_armed = 1'b0;
      nxt_st.enable = 1'b0;
      nxt_st.master = 1'b0;
      nxt_st.state = spi_ctl_pkg::ST_IDLE;
      fifo_take = 1'b0;
    end

    // pin drivers
    nxt_st.sck_oe = st_ff.master;
    nxt_st.mosi = out_bit(nxt_st.tx_sr, frame_16bit_i, lsb_first_i);
    nxt_st.miso = nxt_st.mosi;
    nxt_st.mosi_oe = st_ff.master && tx_cap
                     && (st_ff.enable || st_ff.state != spi_ctl_pkg::ST_IDLE);
    nxt_st.miso_oe = slave_act && tx_cap;
    nxt_st.cs = spi_ctl_pkg::CS_DRIVE_LVL;
    nxt_st.cs_oe = st_ff.master && hw_select_output_enable_i && !soft_select_enable_i
                   && (st_ff.enable || st_ff.state != spi_ctl_pkg::ST_IDLE);

    // status
    nxt_st.tx_empty = !fifo_valid;
    nxt_st.busy = (nxt_st.state != spi_ctl_pkg::ST_IDLE);
    nxt_st.err_irq = error_interrupt_enable_i && (nxt_st.fault || nxt_st.overflow);
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.cs_s1 <= 1'b1;
      st_ff.cs_s2 <= 1'b1;
      st_ff.tx_empty <= spi_ctl_pkg::TX_EMPTY_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from the state register
  assign rx_data_o = st_ff.rx_data;
  assign interface_enable_o = st_ff.enable;
  assign master_select_o = st_ff.master;
  assign mode_fault_flag_o = st_ff.fault;
  assign rx_buffer_full_flag_o = st_ff.rx_full;
  assign rx_overflow_flag_o = st_ff.overflow;
  assign tx_buffer_empty_flag_o = st_ff.tx_empty;
  assign busy_flag_o = st_ff.busy;
  assign error_irq_o = st_ff.err_irq;
  assign sck_o = st_ff.sck;
  assign sck_oe_o = st_ff.sck_oe;
  assign mosi_o = st_ff.mosi;
  assign mosi_oe_o = st_ff.mosi_oe;
  assign miso_o = st_ff.miso;
  assign miso_oe_o = st_ff.miso_oe;
  assign cs_o = st_ff.cs;
  assign cs_oe_o = st_ff.cs_oe;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_duplex_drives_mosi: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff.master && st_ff.enable && !single_line_enable_i && !receive_only_select_i
    |=> mosi_oe_o && !miso_oe_o) else $error("full duplex master not driving mosi");
  a_rxonly_releases_mosi: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !single_line_enable_i && receive_only_select_i |=> !mosi_oe_o && !miso_oe_o)
    else $error("receive-only still drives a data line");
  a_bidir_master_miso: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff.master |=> !miso_oe_o) else $error("master drives miso");
  a_bidir_rx_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    single_line_enable_i && !single_line_direction_i |=> !mosi_oe_o && !miso_oe_o)
    else $error("single-line receive drives a line");
  a_hw_select_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff.master && st_ff.enable && hw_select_output_enable_i && !soft_select_enable_i
    |=> cs_oe_o && !cs_o) else $error("chip select not driven low");
  a_fault_drops_mode: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff.master && !soft_select_enable_i && !hw_select_output_enable_i && !st_ff.cs_s2
    |=> mode_fault_flag_o && !interface_enable_o && !master_select_o ##1 !sck_oe_o)
    else $error("select input low did not fault");
  a_fault_blocks_set: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff.fault && ctrl_write_i && (ctrl_enable_i || ctrl_master_i)
    |=> !interface_enable_o && !master_select_o) else $error("set accepted under fault");
  a_soft_select_fault: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff.master && soft_select_enable_i && !soft_select_level_i |=> st_ff.fault)
    else $error("soft select zero did not fault");
  a_slave_deselect: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !st_ff.master && !soft_select_enable_i && st_ff.cs_s2 |=> !miso_oe_o && !busy_flag_o)
    else $error("deselected slave active");
  a_rxonly_starts: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff.master && st_ff.enable && st_ff.state == spi_ctl_pkg::ST_IDLE
    && !single_line_enable_i && receive_only_select_i && !soft_select_enable_i
    && hw_select_output_enable_i |=> st_ff.state == spi_ctl_pkg::ST_SHIFT)
    else $error("receive-only master clock did not start");
  a_sck_idle_level: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    st_ff.state != spi_ctl_pkg::ST_SHIFT |=> sck_o == $past(clock_idle_polarity_i))
    else $error("serial clock not at idle level");

endmodule : spi_mode_cs_sck_control

`default_nettype wire

// ### core/spi_tx_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module spi_tx_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // draining side
  input wire logic out_ready_i,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic in_rdy;
    logic out_vld;
  } fifo_state_t;

  fifo_state_t st_ff;
  fifo_state_t nxt_st;

  // -----------------------------------------------------------------
  // pointer and occupancy update
  // -----------------------------------------------------------------
  always_comb begin
    logic push;
    logic pop;
    push = in_valid_i && st_ff.in_rdy;
    pop = out_ready_i && st_ff.out_vld;
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr_ptr] = in_data_i;
      nxt_st.wr_ptr = (st_ff.wr_ptr == PTR_LAST) ? '0 : st_ff.wr_ptr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd_ptr = (st_ff.rd_ptr == PTR_LAST) ? '0 : st_ff.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
    nxt_st.in_rdy = (nxt_st.count != CNT_FULL);  // honest full
    nxt_st.out_vld = (nxt_st.count != '0);        // honest empty
  end

  // -----------------------------------------------------------------
  // state register
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.in_rdy <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready_o = st_ff.in_rdy;
  assign out_valid_o = st_ff.out_vld;
  assign out_data_o = st_ff.mem[st_ff.rd_ptr];

endmodule : spi_tx_fifo

`default_nettype wire

// ### test/spi_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// far slave: samples on one clock edge, shifts out on the other
module spi_far_model (
  // serial pins
  input wire logic sck_w,
  input wire logic sdi_w,
  input wire logic sel_n_w,
  output logic sdo_w,
  // frame format, reply word and last word seen
  input wire logic pol_i,
  input wire logic pha_i,
  input wire logic f16_i,
  input wire logic lsb_i,
  input wire logic [15:0] reply_i,
  output logic [15:0] got_o
);
  int k;
  logic [15:0] sh;
  function automatic int pos(input int b);
    return lsb_i ? b : (f16_i ? 15 : 7) - b;
  endfunction : pos
  // selection restarts the frame; first bit is ready before the first edge
  always @(negedge sel_n_w) begin
    k = 0;
    sh = '0;
    sdo_w = reply_i[pos(0)];
  end
  // the master's clock paces both directions
  always @(sck_w) begin
    if (!sel_n_w && ((sck_w != pol_i) ^ pha_i)) begin
      sh[pos(k)] = sdi_w;
      k++;
      if (k == (f16_i ? 16 : 8)) begin
        got_o = sh;
        k = 0;
        sh = '0;
      end
    end else if (!sel_n_w) begin
      sdo_w = reply_i[pos(k)];
    end
  end
endmodule : spi_far_model
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // design pins and bench state
  logic ref_clk_i, rst_i, ctrl_write_i, ctrl_enable_i, ctrl_master_i, status_access_i;
  logic single_line_enable_i, receive_only_select_i, single_line_direction_i;
  logic hw_select_output_enable_i, soft_select_enable_i, soft_select_level_i;
  logic error_interrupt_enable_i, clock_idle_polarity_i, clock_sample_phase_i;
  logic [spi_ctl_pkg::DIV_W-1:0] master_clock_divider_i;
  logic extended_divider_enable_i, frame_16bit_i, lsb_first_i, tx_valid_i, tx_ready_o;
  logic [spi_ctl_pkg::FRAME_W-1:0] tx_data_i, rx_data_o, reply, got, d;
  logic rx_read_i, overflow_clear_i, interface_enable_o, master_select_o, mode_fault_flag_o;
  logic rx_buffer_full_flag_o, rx_overflow_flag_o, tx_buffer_empty_flag_o, busy_flag_o;
  logic error_irq_o, sck_i, sck_o, sck_oe_o, mosi_i, mosi_o, mosi_oe_o, miso_i, miso_o;
  logic miso_oe_o, cs_i, cs_o, cs_oe_o, cs_drv, flip, sdo, full_q, sck_q, pol_q;
  logic [1:0] oe_acc;
  logic slv, sck_drv, mdat;
  logic [7:0] sw;
  logic [15:0] exp_q[$];
  int err_total, checks, cyc, last_t, hp;
  integer seed;
  // released data lines toggle, chip select is pulled up; slv makes the bench the master
  assign cs_i = cs_oe_o ? cs_o : cs_drv;
  assign sck_i = sck_oe_o ? sck_o : slv ? sck_drv : clock_idle_polarity_i;
  assign miso_i = miso_oe_o ? miso_o : (cs_i | single_line_enable_i) ? flip : sdo;
  assign mosi_i = mosi_oe_o ? mosi_o : slv ? mdat : (cs_i | ~single_line_enable_i) ? flip : sdo;
  spi_mode_cs_sck_control dut_u (.*);
  spi_far_model far_u (.sck_w(sck_i), .sdi_w(mosi_i), .sel_n_w(cs_i), .sdo_w(sdo),
    .pol_i(clock_idle_polarity_i), .pha_i(clock_sample_phase_i), .f16_i(frame_16bit_i),
    .lsb_i(lsb_first_i), .reply_i(reply), .got_o(got));
  // clock
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  // reads each full buffer at once; toggles released lines
  always @(posedge ref_clk_i) begin
    rx_read_i <= #2 rx_buffer_full_flag_o & ~rx_read_i;
    flip <= #2 ~flip;
  end
  function automatic logic [15:0] fmask(input logic [15:0] v);
    return frame_16bit_i ? v : {8'h00, v[7:0]};
  endfunction : fmask
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] sv);
    checks++;
    if (sv !== ex) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, ex, sv);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  // watcher: half period, idle level, pin drive, received words, time limit
  always @(negedge ref_clk_i) begin
    cyc++;
    if (sck_oe_o && sck_o !== sck_q) begin
      hp = cyc - last_t;
      last_t = cyc;
    end
    if (sck_oe_o && !busy_flag_o && pol_q === clock_idle_polarity_i)
      chk("sck_o idle", 16'(pol_q), 16'(sck_o));
    oe_acc |= {mosi_oe_o, miso_oe_o};
    if (rx_buffer_full_flag_o && !full_q)
      chk("rx_data_o", exp_q.size() ? exp_q.pop_front() : 16'hDEAD, rx_data_o);
    full_q = rx_buffer_full_flag_o;
    sck_q = sck_o;
    pol_q = clock_idle_polarity_i;
    if (cyc > 90000) begin
      chk("time limit", 16'h0000, 16'h0001);
      end_of_test();
    end
  end
  task automatic tick(input int n = 1);
    repeat (n) @(posedge ref_clk_i);
    #2;
  endtask : tick
  task automatic wr(input logic en, input logic ms);
    ctrl_enable_i = en;
    ctrl_master_i = ms;
    ctrl_write_i = 1'b1;
    tick();
    ctrl_write_i = 1'b0;
  endtask : wr
  task automatic push(input logic [15:0] v);
    tx_data_i = v;
    tx_valid_i = 1'b1;
    for (int t = 0; t < 3000 && tx_ready_o !== 1'b1; t++) tick();
    tick();
    tx_valid_i = 1'b0;
  endtask : push
  task automatic wait_idle;
    int q;
    q = 0;
    for (int t = 0; t < 4000 && q < 8; t++) begin
      tick();
      q = (busy_flag_o | ~tx_buffer_empty_flag_o) ? 0 : q + 1;
    end
    chk("idle", 16'h0008, 16'(q));
  endtask : wait_idle
  // main sequence
  initial begin
    seed = 32'h9A78;
    {rst_i, hw_select_output_enable_i, cs_drv, flip} = 4'hF;
    slv = 1'b0;
    {ctrl_write_i, ctrl_enable_i, ctrl_master_i, status_access_i, single_line_enable_i} = '0;
    {receive_only_select_i, single_line_direction_i, soft_select_enable_i} = '0;
    {soft_select_level_i, error_interrupt_enable_i, clock_idle_polarity_i} = '0;
    {clock_sample_phase_i, extended_divider_enable_i, frame_16bit_i, lsb_first_i} = '0;
    {tx_valid_i, rx_read_i, overflow_clear_i, master_clock_divider_i, tx_data_i, reply} = '0;
    tick(5);
    rst_i = 1'b0;
    chk("reset", 16'h0003, {interface_enable_o, mode_fault_flag_o, tx_buffer_empty_flag_o,
      tx_ready_o});
    // full duplex master over every size, order, phase and polarity
    for (int i = 0; i < 16; i++) begin
      {frame_16bit_i, lsb_first_i, clock_sample_phase_i, clock_idle_polarity_i} = 4'(i);
      master_clock_divider_i = 4'(2 + $unsigned($random(seed)) % 6);
      extended_divider_enable_i = (i == 15);
      reply = 16'($random(seed));
      d = 16'($random(seed));
      exp_q.push_back(fmask(reply));
      oe_acc = '0;
      wr(1'b1, 1'b1);
      push(d);
      wait_idle();
      chk("cs_oe_o", 16'h0001, 16'(cs_oe_o));
      chk("mosi word", fmask(d), got);
      chk("half period", 16'({extended_divider_enable_i, master_clock_divider_i}) + 16'h0001,
        16'(hp));
      chk("pin drive", 16'h0002, 16'(oe_acc));
      wr(1'b0, 1'b1);
      tick(3);
      chk("cs_oe_o", 16'h0000, 16'(cs_oe_o));
    end
    // fill the buffer while disabled until it refuses, then drain back to back
    tx_valid_i = 1'b1;
    for (int j = 0; j < 5; j++) begin
      tx_data_i = 16'($random(seed));
      if (j == 3) d = tx_data_i;
      if (j < 4) exp_q.push_back(fmask(reply));
      tick();
    end
    chk("tx_ready_o", 16'h0000, 16'(tx_ready_o));
    tx_valid_i = 1'b0;
    wr(1'b1, 1'b1);
    wait_idle();
    chk("mosi word", fmask(d), got);
    chk("rx left", 16'h0000, 16'(exp_q.size()));
    wr(1'b0, 1'b1);
    tick(3);
    // receive-only, then single-line receive: clock runs with no data
    for (int m = 0; m < 2; m++) begin
      receive_only_select_i = !m;
      single_line_enable_i = 1'(m);
      repeat (8) exp_q.push_back(fmask(reply));
      oe_acc = '0;
      wr(1'b1, 1'b1);
      for (int t = 0; t < 20000 && exp_q.size() > 5; t++) tick();
      chk("rx frames", 16'h0005, 16'(exp_q.size()));
      wr(1'b0, 1'b1);
      wait_idle();
      chk("pin drive", 16'h0000, 16'(oe_acc));
      chk("cs_oe_o", 16'h0000, 16'(cs_oe_o));
      exp_q.delete();
    end
    // single-line transmit
    single_line_direction_i = 1'b1;
    d = 16'($random(seed));
    oe_acc = '0;
    wr(1'b1, 1'b1);
    push(d);
    wait_idle();
    chk("mosi word", fmask(d), got);
    chk("pin drive", 16'h0002, 16'(oe_acc));
    wr(1'b0, 1'b1);
    tick(3);
    single_line_enable_i = 1'b0;
    // mode fault from the soft level, then from the select pin
    hw_select_output_enable_i = 1'b0;
    for (int f = 0; f < 2; f++) begin
      soft_select_enable_i = !f;
      soft_select_level_i = 1'b1;
      error_interrupt_enable_i = 1'(f);
      tick();
      wr(1'b1, 1'b1);
      tick(3);
      if (f) cs_drv = 1'b0;
      else soft_select_level_i = 1'b0;
      tick(5);
      chk("fault", {3'b100, 1'(f)}, {mode_fault_flag_o, interface_enable_o, master_select_o,
        error_irq_o});
      cs_drv = 1'b1;
      soft_select_level_i = 1'b1;
      wr(1'b1, 1'b1);
      tick();
      chk("refused", 16'h0000, {interface_enable_o, master_select_o});
      status_access_i = 1'b1;
      tick();
      status_access_i = 1'b0;
      chk("fault held", 16'h0001, 16'(mode_fault_flag_o));
      wr(1'b0, 1'b0);
      tick();
      chk("fault clear", 16'h0000, 16'(mode_fault_flag_o));
    end
    // slave on the soft level with the pin high; the bench is master, 8 clocks a half
    {clock_sample_phase_i, clock_idle_polarity_i, frame_16bit_i, lsb_first_i} = '0;
    {slv, sck_drv, soft_select_enable_i, soft_select_level_i} = 4'hA;
    d = 16'($random(seed));
    reply = 16'($random(seed));
    exp_q.push_back(fmask(reply));
    push(d);
    tick(4);
    wr(1'b1, 1'b0);
    tick(8);
    for (int b = 7; b >= 0; b--) begin
      mdat = reply[b];
      tick(8);
      sck_drv = 1'b1;
      sw[b] = miso_i;
      tick(8);
      sck_drv = 1'b0;
    end
    tick(8);
    wr(1'b0, 1'b0);
    wait_idle();
    chk("miso word", fmask(d), 16'(sw));
    chk("overflow", 16'h0000, 16'(rx_overflow_flag_o));
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
